// ### logic/cod_dev.sv
/*
  Device end: decodes command and data bytes, keeps the address counter,
  glyph and text RAMs, the read pipeline and the panel settings.
  Assumes the host waits for ack and polls busy before each instruction.
*/
// How it works
// - 01xxxxxx command loads glyph address
// - 1xxxxxxx command loads text address
// - One-line text addresses run 00H to 4FH
// - Two lines: 00H-27H then 40H-67H
// - Three lines: 00H, 20H, 40H spans of 14H
// - Four lines add 60H-73H span
// - Extended 1x command sets scroll quantity while panel set is off
// - Status read: busy bit 7, value below
// - Host polls busy before next instruction
// - Status reads alternate counter and part id
// - Data write goes to selected RAM
// - Write steps counter per entry direction
// - First read after address set is dummy
// - Cursor shift also reloads text output
// - Read steps counter per entry direction
// - 71h then 5Ch or 00h sets regulator
// - 72h selects glyph count and rom bank
// - 78h clears, 79h sets panel command set
// - 81h then byte sets contrast
// - D5h sets divide ratio and oscillator
// - D9h sets two phase lengths
// - DAh segment map affects later data only
// - Scroll and display extras need extended enable
`timescale 1ns/1ps
module cod_dev (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host link
  cod_link_if.dev lnk,
  // Panel settings
  output logic [7:0] contrast,
  output logic [7:0] clk_div_osc,
  output logic [7:0] phase_len,
  output logic [7:0] seg_map,
  output logic [7:0] desel_level,
  output logic [7:0] vsl_gpio,
  output logic [7:0] glyph_sel,
  output logic [5:0] scroll_quantity,
  output logic [7:0] ext_ctrl,
  output logic regulator_on,
  output logic oled_command_select,
  output logic busy_flag
);
  logic [7:0] text_ram [0:127];
  logic [7:0] glyph_ram [0:63];
  logic [6:0] address_counter_ff;
  logic to_glyph_ff;
  logic up_ff;
  logic ext_ff;
  logic line_count_ff;
  logic four_line_ff;
  logic id_turn_ff;
  logic [7:0] out_reg_ff;
  logic [7:0] param_cmd_ff;
  logic param_wait_ff;
  logic [3:0] busy_cnt_ff;
  logic ack_ff;
  logic [7:0] rdata_ff;
  logic [7:0] contrast_ff;
  logic [7:0] clkdiv_ff;
  logic [7:0] phase_ff;
  logic [7:0] segmap_ff;
  logic [7:0] desel_ff;
  logic [7:0] vsl_ff;
  logic [7:0] glyph_ff;
  logic [5:0] scroll_ff;
  logic [7:0] ext_ctrl_ff;
  logic reg_on_ff;
  logic sd_ff;
  logic [6:0] step_addr;

  wire [7:0] b = lnk.wdata;
  wire cmd_wr = lnk.stb && !lnk.dc && !lnk.rd;
  wire cmd_rd = lnk.stb && !lnk.dc && lnk.rd;
  wire dat_wr = lnk.stb && lnk.dc && !lnk.rd;
  wire dat_rd = lnk.stb && lnk.dc && lnk.rd;
  wire is_param = cmd_wr && param_wait_ff;
  wire is_cmd = cmd_wr && !param_wait_ff;
  wire set_glyph = is_cmd && !ext_ff && b[7:6] == 2'b01;
  wire set_text = is_cmd && !ext_ff && b[7];
  wire set_scroll = is_cmd && ext_ff && !sd_ff && b[7];
  wire func_set = is_cmd && b[7:5] == 3'b001;
  wire shift_cmd = is_cmd && !ext_ff && b[7:4] == 4'b0001;
  wire cur_shift = shift_cmd && !b[cod_pkg::SH_SC];
  wire ext_low = is_cmd && ext_ff && b[7:4] == 4'b0001;
  wire entry_cmd = is_cmd && !ext_ff && b[7:2] == 6'b000001;
  wire two_byte = (ext_ff && (b == cod_pkg::CMD_FUNC_A ||
    b == cod_pkg::CMD_FUNC_B)) || (sd_ff && (b == cod_pkg::CMD_CONTRAST ||
    b == cod_pkg::CMD_CLKDIV || b == cod_pkg::CMD_PHASE ||
    b == cod_pkg::CMD_SEGMAP || b == cod_pkg::CMD_DESEL ||
    b == cod_pkg::CMD_VSLGPIO));
  wire open_param = is_cmd && two_byte;
  wire stepping = dat_wr || dat_rd || cur_shift;
  wire step_up = cur_shift ? b[cod_pkg::SH_RL] : up_ff;
  wire [6:0] glyph_next = {1'b0, address_counter_ff[5:0] +
    (step_up ? 6'h01 : 6'h3f)};
  wire [6:0] ac_next = to_glyph_ff ? glyph_next : step_addr;
  wire [6:0] new_ac = set_glyph ? {1'b0, b[5:0]} : set_text ? b[6:0] :
    stepping ? ac_next : address_counter_ff;
  wire [5:0] sq_val = (b[5:4] == 2'b11) ? cod_pkg::SCROLL_MAX : b[5:0];
  wire [7:0] ram_now = to_glyph_ff ? glyph_ram[address_counter_ff[5:0]] :
    text_ram[address_counter_ff];
  wire [7:0] stat_byte = {busy_cnt_ff != 4'h0,
    id_turn_ff ? cod_pkg::PART_ID : address_counter_ff};
  cod_text_addr u_text_addr (
    .four_line_width_bit(four_line_ff),
    .line_count_bit(line_count_ff),
    .up(step_up),
    .cur(address_counter_ff),
    .nxt(step_addr)
  );

  always_ff @(posedge ref_clk) begin
    if (dat_wr && to_glyph_ff) begin
      glyph_ram[address_counter_ff[5:0]] <= b;
    end
    if (dat_wr && !to_glyph_ff) begin
      text_ram[address_counter_ff] <= b;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_counter_ff <= 7'h00;
      to_glyph_ff <= 1'b0;
      up_ff <= 1'b1;
      ext_ff <= 1'b0;
      line_count_ff <= 1'b0;
      four_line_ff <= 1'b0;
      id_turn_ff <= 1'b0;
      out_reg_ff <= 8'h00;
      param_cmd_ff <= 8'h00;
      param_wait_ff <= 1'b0;
      busy_cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= lnk.stb;
      address_counter_ff <= new_ac;
      if (set_glyph) begin
        to_glyph_ff <= 1'b1;
      end else if (set_text) begin
        to_glyph_ff <= 1'b0;
      end
      if (entry_cmd) begin
        up_ff <= b[cod_pkg::EM_ID];
      end
      if (func_set) begin
        ext_ff <= b[cod_pkg::FS_RE];
        line_count_ff <= b[cod_pkg::FS_N];
      end
      if (is_cmd && ext_ff && b[7:3] == 5'b00001) begin
        four_line_ff <= b[0];
      end
      if (cmd_rd) begin
        id_turn_ff <= !id_turn_ff;
        rdata_ff <= stat_byte;
      end else if (lnk.stb) begin
        id_turn_ff <= 1'b0;
      end
      // Output register holds the byte before the counter moves
      if (dat_rd) begin
        rdata_ff <= out_reg_ff;
        out_reg_ff <= ram_now;
      end else if (set_glyph || set_text || cur_shift) begin
        out_reg_ff <= ram_now;
      end
      if (open_param) begin
        param_wait_ff <= 1'b1;
        param_cmd_ff <= b;
      end else if (is_param) begin
        param_wait_ff <= 1'b0;
      end
      if (cmd_wr || dat_wr) begin
        busy_cnt_ff <= 4'(cod_pkg::BUSY_CYC);
      end else if (busy_cnt_ff != 4'h0) begin
        busy_cnt_ff <= busy_cnt_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      contrast_ff <= cod_pkg::CONTRAST_RST;
      clkdiv_ff <= cod_pkg::CLKDIV_RST;
      phase_ff <= cod_pkg::PHASE_RST;
      segmap_ff <= 8'h00;
      desel_ff <= 8'h00;
      vsl_ff <= 8'h00;
      glyph_ff <= 8'h00;
      scroll_ff <= 6'h00;
      ext_ctrl_ff <= 8'h00;
      reg_on_ff <= 1'b1;
      sd_ff <= 1'b0;
    end else begin
      if (set_scroll) begin
        scroll_ff <= sq_val;
      end
      if (ext_low) begin
        ext_ctrl_ff[3:0] <= b[3:0];
      end
      if (is_cmd && ext_ff && b == cod_pkg::CMD_PANEL_OFF) begin
        sd_ff <= 1'b0;
      end else if (is_cmd && ext_ff && b == cod_pkg::CMD_PANEL_ON) begin
        sd_ff <= 1'b1;
      end
      if (is_param) begin
        case (param_cmd_ff)
          cod_pkg::CMD_FUNC_A: begin
            if (b == cod_pkg::REG_ON_VAL) begin
              reg_on_ff <= 1'b1;
            end else if (b == cod_pkg::REG_OFF_VAL) begin
              reg_on_ff <= 1'b0;
            end
          end
          cod_pkg::CMD_FUNC_B: glyph_ff <= b;
          cod_pkg::CMD_CONTRAST: contrast_ff <= b;
          cod_pkg::CMD_CLKDIV: clkdiv_ff <= b;
          cod_pkg::CMD_PHASE: phase_ff <= b;
          cod_pkg::CMD_SEGMAP: segmap_ff <= b;
          cod_pkg::CMD_DESEL: desel_ff <= b;
          cod_pkg::CMD_VSLGPIO: vsl_ff <= b;
          default: ;
        endcase
      end
    end
  end

  assign lnk.ack = ack_ff;
  assign lnk.rdata = rdata_ff;
  assign contrast = contrast_ff;
  assign clk_div_osc = clkdiv_ff;
  assign phase_len = phase_ff;
  assign seg_map = segmap_ff;
  assign desel_level = desel_ff;
  assign vsl_gpio = vsl_ff;
  assign glyph_sel = glyph_ff;
  assign scroll_quantity = scroll_ff;
  assign ext_ctrl = ext_ctrl_ff;
  assign regulator_on = reg_on_ff;
  assign oled_command_select = sd_ff;
  assign busy_flag = busy_cnt_ff != 4'h0;
endmodule

// ### logic/cod_host.sv
/*
  Host end: APB slave that turns register writes into link cycles.
  Writing CMD or DATA starts a write; writing STAT bit 1 or 2 starts a
  status or data read. Assumes software polls the device busy bit.
*/
`timescale 1ns/1ps
module cod_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device link
  cod_link_if.host lnk
);
  cod_pkg::cod_cyc_t st_ff;
  logic stb_ff;
  logic dc_ff;
  logic rd_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rbyte_ff;
  logic done_ff;

  wire acc = psel && penable;
  wire idle = st_ff == cod_pkg::CY_IDLE;
  wire wr_cmd = acc && pwrite && paddr == cod_pkg::A_CMD;
  wire wr_dat = acc && pwrite && paddr == cod_pkg::A_DATA;
  wire wr_st = acc && pwrite && paddr == cod_pkg::A_STAT;
  wire go = idle && (wr_cmd || wr_dat || (wr_st && |pwdata[2:1]));
  wire mapped = paddr == cod_pkg::A_CMD || paddr == cod_pkg::A_DATA ||
    paddr == cod_pkg::A_STAT || paddr == cod_pkg::A_RDATA;
  wire [31:0] stat_word = {30'h0, done_ff, !idle};

  // Busy host holds link writes until the cycle ends
  assign pready = !(pwrite && (wr_cmd || wr_dat || wr_st) && !idle);
  assign pslverr = acc && !mapped;
  assign prdata = (paddr == cod_pkg::A_STAT) ? stat_word :
    (paddr == cod_pkg::A_RDATA) ? {24'h0, rbyte_ff} : 32'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= cod_pkg::CY_IDLE;
      stb_ff <= 1'b0;
      dc_ff <= 1'b0;
      rd_ff <= 1'b0;
      wdata_ff <= 8'h00;
      rbyte_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      stb_ff <= 1'b0;
      case (st_ff)
        cod_pkg::CY_IDLE: begin
          if (go) begin
            stb_ff <= 1'b1;
            dc_ff <= wr_dat || (wr_st && pwdata[2]);
            rd_ff <= wr_st;
            wdata_ff <= pwdata[7:0];
            done_ff <= 1'b0;
            st_ff <= cod_pkg::CY_WAIT;
          end
        end
        cod_pkg::CY_WAIT: begin
          if (lnk.ack) begin
            if (rd_ff) begin
              rbyte_ff <= lnk.rdata;
            end
            done_ff <= 1'b1;
            st_ff <= cod_pkg::CY_IDLE;
          end
        end
        default: st_ff <= cod_pkg::CY_IDLE;
      endcase
    end
  end

  assign lnk.stb = stb_ff;
  assign lnk.dc = dc_ff;
  assign lnk.rd = rd_ff;
  assign lnk.wdata = wdata_ff;
endmodule

// ### logic/cod_link_if.sv
/*
  Byte link between host controller and display command decoder.
  Assumes one shared clock; strobe is a one-cycle request, ack answers.
*/
`timescale 1ns/1ps
interface cod_link_if;
  logic stb;
  logic dc;
  logic rd;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport host (output stb, output dc, output rd, output wdata,
    input ack, input rdata);
  modport dev (input stb, input dc, input rd, input wdata,
    output ack, output rdata);
endinterface

// ### logic/cod_pkg.sv
/*
  Shared constants for the character display command decoder: the host
  bus cycle kinds, command codes, address ranges, reset values and the
  controller's own register map.
  Assumes both ends and the bench compile this package first.
*/
package cod_pkg;
  // Command byte codes and regulator values
  localparam logic [7:0] CMD_FUNC_A = 8'h71;
  localparam logic [7:0] CMD_FUNC_B = 8'h72;
  localparam logic [7:0] CMD_PANEL_OFF = 8'h78;
  localparam logic [7:0] CMD_PANEL_ON = 8'h79;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_CLKDIV = 8'hd5;
  localparam logic [7:0] CMD_PHASE = 8'hd9;
  localparam logic [7:0] CMD_SEGMAP = 8'hda;
  localparam logic [7:0] CMD_DESEL = 8'hdb;
  localparam logic [7:0] CMD_VSLGPIO = 8'hdc;
  localparam logic [7:0] REG_ON_VAL = 8'h5c;
  localparam logic [7:0] REG_OFF_VAL = 8'h00;
  // Function set / shift opcode fields
  localparam int FS_BIT = 5;
  localparam int FS_N = 3;
  localparam int FS_RE = 1;
  localparam int SH_BIT = 4;
  localparam int SH_SC = 3;
  localparam int SH_RL = 2;
  localparam int EM_BIT = 2;
  localparam int EM_ID = 1;
  // Text RAM line bounds
  localparam logic [6:0] ONE_LAST = 7'h4f;
  localparam logic [6:0] TWO_L1_LAST = 7'h27;
  localparam logic [6:0] TWO_L2_FIRST = 7'h40;
  localparam logic [6:0] TWO_L2_LAST = 7'h67;
  localparam logic [4:0] FOUR_COL_LAST = 5'h13;
  localparam logic [6:0] LINE_STEP = 7'h20;
  // Scroll quantity limit
  localparam logic [5:0] SCROLL_MAX = 6'h30;
  // Reset values
  localparam logic [7:0] CLKDIV_RST = 8'h70;
  localparam logic [7:0] PHASE_RST = 8'h22;
  localparam logic [7:0] CONTRAST_RST = 8'h7f;
  localparam logic [6:0] PART_ID = 7'h2a; // Arbitrary value
  // Busy time in cycles of the 100 MHz clock
  localparam int BUSY_NS = 100;
  localparam int CLK_NS = 10;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  // Host controller APB map
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_RDATA = 8'h0c;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_REQ = 2'b01,
    CY_WAIT = 2'b10
  } cod_cyc_t;
endpackage

// ### logic/cod_text_addr.sv
/*
  Next text RAM address after a step, folded into the active line map.
  Assumes combinational use inside the decoder.
*/
`timescale 1ns/1ps
module cod_text_addr (
  // Mode
  input wire logic four_line_width_bit,
  input wire logic line_count_bit,
  input wire logic up,
  // Address
  input wire logic [6:0] cur,
  output logic [6:0] nxt
);
  wire [6:0] inc = cur + 7'h01;
  wire [6:0] dec = cur - 7'h01;
  wire [4:0] col = cur[4:0];
  wire [1:0] ln = cur[6:5];
  wire [1:0] nl = line_count_bit ? 2'h3 : 2'h2;
  wire [1:0] ln_up = (ln == nl) ? 2'h0 : ln + 2'h1;
  wire [1:0] ln_dn = (ln == 2'h0) ? nl : ln - 2'h1;
  wire [6:0] n4_up = (col == cod_pkg::FOUR_COL_LAST) ?
    {ln_up, 5'h00} : inc;
  wire [6:0] n4_dn = (col == 5'h00) ?
    {ln_dn, cod_pkg::FOUR_COL_LAST} : dec;
  wire [6:0] n2_up = (cur == cod_pkg::TWO_L1_LAST) ? cod_pkg::TWO_L2_FIRST :
    (cur == cod_pkg::TWO_L2_LAST) ? 7'h00 : inc;
  wire [6:0] n2_dn = (cur == cod_pkg::TWO_L2_FIRST) ? cod_pkg::TWO_L1_LAST :
    (cur == 7'h00) ? cod_pkg::TWO_L2_LAST : dec;
  wire [6:0] n1_up = (cur == cod_pkg::ONE_LAST) ? 7'h00 : inc;
  wire [6:0] n1_dn = (cur == 7'h00) ? cod_pkg::ONE_LAST : dec;
  always_comb begin
    if (four_line_width_bit) begin
      nxt = up ? n4_up : n4_dn;
    end else if (line_count_bit) begin
      nxt = up ? n2_up : n2_dn;
    end else begin
      nxt = up ? n1_up : n1_dn;
    end
  end
endmodule

// ### verification/cod_link_assertions.sv
/*
  Checker for the byte link between host end and device end.
  Assumes it sees the link signals of the interface that joins the ends.
*/
`timescale 1ns/1ps
module cod_link_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  input wire logic stb,
  input wire logic dc,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] since_wr_ff;
  logic alt_ff;
  logic re_ff;
  logic txt_ff;
  logic [6:0] txt_val_ff;
  wire cmd_wr = stb && !dc && !rd;
  wire stat_rd = stb && !dc && rd;
  wire fs_cmd = cmd_wr && (wdata[7:5] == 3'b001);
  // Cycles since a write, alternation and last text address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_wr_ff <= 5'h1f;
      alt_ff <= 1'b0;
      re_ff <= 1'b0;
      txt_ff <= 1'b0;
      txt_val_ff <= 7'h00;
    end else begin
      if (stb && !rd) since_wr_ff <= 5'h00;
      else if (since_wr_ff != 5'h1f) since_wr_ff <= since_wr_ff + 5'h01;
      if (stb) alt_ff <= stat_rd && !alt_ff;
      if (stb) txt_ff <= cmd_wr && wdata[7] && !re_ff;
      if (cmd_wr) txt_val_ff <= wdata[6:0];
      if (fs_cmd) re_ff <= wdata[1];
    end
  end
  a_ack_one_later: assert property (stb |=> ack)
    else $error("ack missing one cycle after strobe");
  a_ack_has_cause: assert property (ack |-> $past(stb))
    else $error("ack without strobe");
  a_single_request: assert property (stb |=> !stb)
    else $error("second request while one outstanding");
  a_rdata_on_read: assert property (
    !$stable(rdata) |-> $past(stb && rd))
    else $error("read data changed without a read");
  a_busy_after_write: assert property (
    stat_rd && since_wr_ff <= 5'h05 |=> rdata[7])
    else $error("busy bit low just after a write");
  a_idle_not_busy: assert property (
    stat_rd && since_wr_ff >= 5'h0e |=> !rdata[7])
    else $error("busy bit high long after last write");
  a_second_is_id: assert property (
    stat_rd && alt_ff |=> rdata[6:0] == cod_pkg::PART_ID)
    else $error("second status read not part identifier");
  a_first_is_addr: assert property (
    stat_rd && txt_ff |=> rdata[6:0] == txt_val_ff)
    else $error("status read not the loaded text address");
endmodule

// ### verification/tb.sv
/*
  Testbench joining host end and device end over the byte link.
  Assumes software reaches the host end over APB at 100 MHz.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, last_err;
  logic [31:0] q;
  logic [7:0] contrast, clk_div_osc, phase_len, seg_map, desel_level;
  logic [7:0] vsl_gpio, glyph_sel, ext_ctrl;
  logic [5:0] scroll_quantity;
  logic regulator_on, oled_command_select, busy_flag;
  int err_count = 0;
  int samples_checked = 0;
  // Command, parameter (bit 8 present), output select, expected
  localparam logic [28:0] ROWS [18] = '{
    {8'h22, 9'h000, 4'h7, 8'h00}, {8'h85, 9'h000, 4'h7, 8'h05},
    {8'haf, 9'h000, 4'h7, 8'h2f}, {8'hbf, 9'h000, 4'h7, 8'h30},
    {8'h80, 9'h000, 4'h7, 8'h00}, {8'h71, 9'h100, 4'h8, 8'h00},
    {8'h71, 9'h15c, 4'h8, 8'h01}, {8'h72, 9'h105, 4'h6, 8'h05},
    {8'h79, 9'h000, 4'h9, 8'h01}, {8'h81, 9'h100, 4'h0, 8'h00},
    {8'h81, 9'h1ff, 4'h0, 8'hff}, {8'hd5, 9'h13f, 4'h1, 8'h3f},
    {8'hd9, 9'h1f2, 4'h2, 8'hf2}, {8'hda, 9'h110, 4'h3, 8'h10},
    {8'hdb, 9'h140, 4'h4, 8'h40}, {8'hdc, 9'h181, 4'h5, 8'h81},
    {8'h78, 9'h000, 4'h9, 8'h00},
    {8'h1b, 9'h000, 4'ha, 8'h0b}};
  // Three mode commands, address command, counter after one write
  localparam logic [39:0] MAPS [8] = '{
    40'h202020cf00, 40'h282828a740, 40'h282828e700,
    40'h2209209320, 40'h220920b340, 40'h220920d300,
    40'h220928d360, 40'h220928f300};
  cod_link_if lnk ();
  always #5 ref_clk = ~ref_clk;
  cod_host u_cod_host (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  cod_dev u_cod_dev (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk),
    .contrast(contrast), .clk_div_osc(clk_div_osc), .phase_len(phase_len),
    .seg_map(seg_map), .desel_level(desel_level), .vsl_gpio(vsl_gpio),
    .glyph_sel(glyph_sel), .scroll_quantity(scroll_quantity),
    .ext_ctrl(ext_ctrl), .regulator_on(regulator_on),
    .oled_command_select(oled_command_select), .busy_flag(busy_flag));
  cod_link_assertions u_cod_link_assertions (.ref_clk(ref_clk),
    .rst_n(rst_n), .stb(lnk.stb), .dc(lnk.dc), .rd(lnk.rd),
    .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
  function automatic logic [7:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = contrast;
      4'h1: obs = clk_div_osc;
      4'h2: obs = phase_len;
      4'h3: obs = seg_map;
      4'h4: obs = desel_level;
      4'h5: obs = vsl_gpio;
      4'h6: obs = glyph_sel;
      4'h7: obs = {2'b00, scroll_quantity};
      4'h8: obs = {7'h00, regulator_on};
      4'h9: obs = {7'h00, oled_command_select};
      default: obs = ext_ctrl;
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start a link cycle and wait for its answer
  task automatic link(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    while (lnk.ack !== 1'b1) begin
      @(posedge ref_clk);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    link(a, b);
    repeat (cod_pkg::BUSY_CYC + 2) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] b);
    put(cod_pkg::A_CMD, b);
  endtask
  task automatic rdl(input logic [7:0] k);
    link(cod_pkg::A_STAT, k);
    apb(1'b0, cod_pkg::A_RDATA, 32'h0);
  endtask
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      cmd(ROWS[i][28:21]);
      if (ROWS[i][20]) cmd(ROWS[i][19:12]);
      chk(obs(ROWS[i][11:8]), ROWS[i][7:0]);
    end
    // Panel commands must not reach the scroll quantity
    chk({2'b00, scroll_quantity}, 8'h00);
    // Reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(contrast, 8'h7f);
    chk(clk_div_osc, cod_pkg::CLKDIV_RST);
    chk(phase_len, cod_pkg::PHASE_RST);
    chk({6'h00, regulator_on, oled_command_select}, 8'h02);
    // Text address with extended enable low, then status alternation
    link(cod_pkg::A_CMD, 8'h85);
    chk({7'h00, busy_flag}, 8'h01);
    rdl(8'h02);
    chk(q[7:0], 8'h85);
    rdl(8'h02);
    chk({1'b0, q[6:0]}, {1'b0, cod_pkg::PART_ID});
    repeat (cod_pkg::BUSY_CYC + 2) @(posedge ref_clk);
    rdl(8'h02);
    chk(q[7:0], 8'h05);
    chk({2'b00, scroll_quantity}, 8'h00);
    // Data writes, dummy read and reads
    cmd(8'h80);
    put(cod_pkg::A_DATA, 8'ha1);
    put(cod_pkg::A_DATA, 8'hb2);
    put(cod_pkg::A_DATA, 8'hc3);
    rdl(8'h02);
    chk(q[7:0], 8'h03);
    cmd(8'h80);
    rdl(8'h04);
    rdl(8'h04);
    chk(q[7:0], 8'ha1);
    rdl(8'h04);
    chk(q[7:0], 8'hb2);
    cmd(8'h82);
    cmd(8'h10);
    chk(ext_ctrl, 8'h00);
    rdl(8'h04);
    chk(q[7:0], 8'hc3);
    rdl(8'h04);
    chk(q[7:0], 8'hb2);
    // Glyph RAM kept apart from text RAM
    cmd(8'h48);
    put(cod_pkg::A_DATA, 8'h5a);
    cmd(8'h48);
    rdl(8'h04);
    rdl(8'h04);
    chk(q[7:0], 8'h5a);
    cmd(8'h80);
    rdl(8'h04);
    rdl(8'h04);
    chk(q[7:0], 8'ha1);
    // Line ends in every line mode
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) cmd(MAPS[i][39-8*j -: 8]);
      put(cod_pkg::A_DATA, 8'h00);
      rdl(8'h02);
      chk({1'b0, q[6:0]}, MAPS[i][7:0]);
    end
    // Decrementing entry mode
    cmd(8'h22);
    cmd(8'h08);
    cmd(8'h20);
    cmd(8'h04);
    cmd(8'h85);
    put(cod_pkg::A_DATA, 8'h11);
    rdl(8'h02);
    chk(q[7:0], 8'h04);
    apb(1'b0, 8'h10, 32'h0);
    chk({7'h00, last_err}, 8'h01);
    chk(q[7:0], 8'h00);
    complete_run();
  end
endmodule
